// *** rtl/operand_address_mode_decoder.v ***
// Purpose: Decodes a general operand mode and forms its effective address
// Assumes: Extension fields arrive from the queue already length-decoded, one per take
// Notes: Pointer fetches go out on a simple request/acknowledge read port
`timescale 1ns/10ps
`default_nettype none
`include "operand_mode_regs.vh"

module operand_address_mode_decoder #(
  parameter ADDR_W = 32,
  parameter NUM_GPR = 8
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Operand request
  input wire i_start,
  input wire [4:0] i_mode,
  input wire i_write,
  input wire i_slave,
  input wire [1:0] i_size_log2,
  output wire o_busy,
  // Instruction queue extension fields
  input wire i_ext_valid,
  input wire [ADDR_W-1:0] i_ext_data,
  output wire o_ext_take,
  // Register file and dedicated registers
  input wire [NUM_GPR*ADDR_W-1:0] i_gpr_flat,
  input wire [ADDR_W-1:0] i_frame_pointer,
  input wire [ADDR_W-1:0] i_static_base,
  input wire [ADDR_W-1:0] i_interrupt_stack_pointer,
  input wire [ADDR_W-1:0] i_user_stack_pointer,
  input wire [ADDR_W-1:0] i_program_counter,
  input wire [ADDR_W-1:0] i_link_table_base,
  input wire i_stack_select,
  // Pointer fetch port
  output reg o_ptr_req,
  output reg [ADDR_W-1:0] o_ptr_addr,
  input wire i_ptr_ack,
  input wire [ADDR_W-1:0] i_ptr_data,
  // Result
  output wire o_done,
  output reg [1:0] o_kind,
  output reg o_illegal,
  output reg [2:0] o_reg_num,
  output reg o_float_reg,
  output reg [ADDR_W-1:0] o_ea,
  output reg [ADDR_W-1:0] o_imm,
  output wire o_stack_update,
  output reg o_stack_user,
  output reg [ADDR_W-1:0] o_stack_value
);

  localparam S_IDLE = 7'b0000001;
  localparam S_INDEX = 7'b0000010;
  localparam S_DISP1 = 7'b0000100;
  localparam S_PTR = 7'b0001000;
  localparam S_DISP2 = 7'b0010000;
  localparam S_SUM = 7'b0100000;
  localparam S_DONE = 7'b1000000;

  // Pick general register n out of the flattened file
  function [ADDR_W-1:0] gpr_pick;
    input [NUM_GPR*ADDR_W-1:0] flat;
    input [2:0] n;
    begin
      gpr_pick = flat[n*ADDR_W +: ADDR_W];
    end
  endfunction

  // Dedicated base for memory-relative and memory-space codes
  function [ADDR_W-1:0] dedicated_base;
    input [1:0] sel;
    input [ADDR_W-1:0] frame;
    input [ADDR_W-1:0] stack;
    input [ADDR_W-1:0] stat;
    input [ADDR_W-1:0] prog;
    begin
      case (sel)
        `BASE_FRAME: dedicated_base = frame;
        `BASE_STACK: dedicated_base = stack;
        `BASE_STATIC: dedicated_base = stat;
        default: dedicated_base = prog;
      endcase
    end
  endfunction

  // Modes that carry a first extension field (displacement or immediate)
  function takes_first_field;
    input [4:0] m;
    begin
      takes_first_field = (m[`MODE_GROUP_HI:`MODE_GROUP_LO] == `MODE_GROUP_RELATIVE) ||
                          (m == `MODE_MEMREL_FRAME) || (m == `MODE_MEMREL_STACK) ||
                          (m == `MODE_MEMREL_STATIC) || (m == `MODE_IMMEDIATE) ||
                          (m == `MODE_ABSOLUTE) || (m == `MODE_LINK_TABLE) ||
                          (m == `MODE_SPACE_FRAME) || (m == `MODE_SPACE_STACK) ||
                          (m == `MODE_SPACE_STATIC) || (m == `MODE_SPACE_PROGRAM);
    end
  endfunction

  function is_scaled;
    input [4:0] m;
    begin
      is_scaled = (m[4:2] == 3'h7);
    end
  endfunction

  reg [6:0] state;
  reg [4:0] base_mode;
  reg indexed;
  reg [1:0] scale;
  reg [2:0] index_reg;
  reg write_op;
  reg [1:0] size_log2;
  reg [ADDR_W-1:0] base_ea;
  reg stack_flag;

  wire [ADDR_W-1:0] stack_now;
  wire [ADDR_W-1:0] size_bytes;
  wire [ADDR_W-1:0] base_reg;
  wire [ADDR_W-1:0] rel_reg;
  wire [ADDR_W-1:0] index_value;
  wire [ADDR_W-1:0] indexed_ea;
  wire first_needed;
  wire first_ready;

  assign stack_now = i_stack_select ? i_user_stack_pointer
                                    : i_interrupt_stack_pointer;
  assign size_bytes = {{(ADDR_W-1){1'b0}}, 1'b1} << size_log2;
  assign base_reg = dedicated_base(base_mode[1:0], i_frame_pointer, stack_now,
                                   i_static_base, i_program_counter);
  assign rel_reg = gpr_pick(i_gpr_flat, base_mode[2:0]);
  assign index_value = gpr_pick(i_gpr_flat, index_reg);
  assign first_needed = takes_first_field(base_mode);
  assign first_ready = !first_needed || i_ext_valid;

  // Queue fields are taken strictly one per state step, so nothing is skipped
  assign o_ext_take = i_ext_valid &&
                      ((state == S_INDEX) ||
                       ((state == S_DISP1) && first_needed) ||
                       (state == S_DISP2));
  assign o_busy = (state != S_IDLE);
  assign o_done = (state == S_DONE);
  assign o_stack_update = o_done && stack_flag;

  ea_index_scaler #(
    .ADDR_W(ADDR_W)
  ) u_scaler (
    .i_base(base_ea),
    .i_index(index_value),
    .i_scale(scale),
    .i_enable(indexed),
    .o_sum(indexed_ea)
  );

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= S_IDLE;
      base_mode <= 5'h00;
      indexed <= 1'b0;
      scale <= 2'h0;
      index_reg <= 3'h0;
      write_op <= 1'b0;
      size_log2 <= 2'h0;
      base_ea <= {ADDR_W{1'b0}};
      stack_flag <= 1'b0;
      o_ptr_req <= 1'b0;
      o_ptr_addr <= {ADDR_W{1'b0}};
      o_kind <= `KIND_REGISTER;
      o_illegal <= 1'b0;
      o_reg_num <= 3'h0;
      o_float_reg <= 1'b0;
      o_ea <= {ADDR_W{1'b0}};
      o_imm <= {ADDR_W{1'b0}};
      o_stack_user <= 1'b0;
      o_stack_value <= {ADDR_W{1'b0}};
    end else begin
      case (state)
        S_IDLE: begin
          if (i_start) begin
            write_op <= i_write;
            size_log2 <= i_size_log2;
            o_float_reg <= i_slave;
            o_illegal <= 1'b0;
            o_kind <= `KIND_MEMORY;
            stack_flag <= 1'b0;
            base_ea <= {ADDR_W{1'b0}};
            if (is_scaled(i_mode)) begin
              // Low two bits of the scaled codes are the log2 of the element size
              indexed <= 1'b1;
              scale <= i_mode[1:0];
              state <= S_INDEX;
            end else begin
              indexed <= 1'b0;
              scale <= 2'h0;
              base_mode <= i_mode;
              state <= S_DISP1;
            end
          end
        end
        S_INDEX: begin
          if (i_ext_valid) begin
            base_mode <= i_ext_data[`INDEX_MODE_HI:`INDEX_MODE_LO];
            index_reg <= i_ext_data[`INDEX_REG_HI:`INDEX_REG_LO];
            if ((i_ext_data[`INDEX_MODE_HI:`INDEX_MODE_LO] == `MODE_IMMEDIATE) ||
                is_scaled(i_ext_data[`INDEX_MODE_HI:`INDEX_MODE_LO])) begin
              // Refused base: report and take no further fields
              o_illegal <= 1'b1;
              o_kind <= `KIND_RESERVED;
              indexed <= 1'b0;
              state <= S_SUM;
            end else begin
              state <= S_DISP1;
            end
          end
        end
        S_DISP1: begin
          if (first_ready) begin
            state <= S_SUM;
            if (base_mode[`MODE_GROUP_HI:`MODE_GROUP_LO] == `MODE_GROUP_DIRECT) begin
              o_reg_num <= base_mode[2:0];
              if (indexed) begin
                base_ea <= rel_reg;
              end else begin
                o_kind <= `KIND_REGISTER;
              end
            end else if (base_mode[`MODE_GROUP_HI:`MODE_GROUP_LO] ==
                         `MODE_GROUP_RELATIVE) begin
              base_ea <= rel_reg + i_ext_data;
            end else begin
              case (base_mode)
                `MODE_MEMREL_FRAME, `MODE_MEMREL_STACK, `MODE_MEMREL_STATIC: begin
                  o_ptr_addr <= base_reg + i_ext_data;
                  o_ptr_req <= 1'b1;
                  state <= S_PTR;
                end
                `MODE_IMMEDIATE: begin
                  o_imm <= i_ext_data;
                  o_kind <= `KIND_IMMEDIATE;
                end
                `MODE_ABSOLUTE: begin
                  base_ea <= i_ext_data;
                end
                `MODE_LINK_TABLE: begin
                  o_ptr_addr <= i_link_table_base +
                                (i_ext_data << `LINK_ENTRY_SHIFT);
                  o_ptr_req <= 1'b1;
                  state <= S_PTR;
                end
                `MODE_TOP_OF_STACK: begin
                  stack_flag <= 1'b1;
                  o_stack_user <= i_stack_select;
                  // Push predecrements and targets the new top; pop reads then moves up
                  if (write_op) begin
                    base_ea <= stack_now - size_bytes;
                    o_stack_value <= stack_now - size_bytes;
                  end else begin
                    base_ea <= stack_now;
                    o_stack_value <= stack_now + size_bytes;
                  end
                end
                `MODE_SPACE_FRAME, `MODE_SPACE_STACK, `MODE_SPACE_STATIC: begin
                  base_ea <= base_reg + i_ext_data;
                end
                `MODE_SPACE_PROGRAM: begin
                  base_ea <= base_reg + i_ext_data;
                end
                default: begin
                  o_kind <= `KIND_RESERVED;
                  o_illegal <= 1'b1;
                  indexed <= 1'b0;
                end
              endcase
            end
          end
        end
        S_PTR: begin
          if (i_ptr_ack) begin
            o_ptr_req <= 1'b0;
            base_ea <= i_ptr_data;
            state <= S_DISP2;
          end
        end
        S_DISP2: begin
          if (i_ext_valid) begin
            base_ea <= base_ea + i_ext_data;
            state <= S_SUM;
          end
        end
        S_SUM: begin
          // Index is added after the base mode has fully resolved
          o_ea <= indexed_ea;
          state <= S_DONE;
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
          o_ptr_req <= 1'b0;
        end
      endcase
    end
  end

endmodule // operand_address_mode_decoder

`default_nettype wire

// *** shared/operand_mode_regs.vh ***
// Purpose: Constants for the operand addressing-mode decoder
// Assumes: 5-bit mode field, 8-bit index byte, 32-bit addresses
// Notes: Definitions only
`ifndef OPERAND_MODE_REGS_VH
`define OPERAND_MODE_REGS_VH

// Mode field
`define MODE_W 5
`define MODE_GROUP_HI 4
`define MODE_GROUP_LO 3
`define MODE_GROUP_DIRECT 2'h0
`define MODE_GROUP_RELATIVE 2'h1

// Individual mode codes
`define MODE_MEMREL_FRAME 5'h10
`define MODE_MEMREL_STACK 5'h11
`define MODE_MEMREL_STATIC 5'h12
`define MODE_RESERVED 5'h13
`define MODE_IMMEDIATE 5'h14
`define MODE_ABSOLUTE 5'h15
`define MODE_LINK_TABLE 5'h16
`define MODE_TOP_OF_STACK 5'h17
`define MODE_SPACE_FRAME 5'h18
`define MODE_SPACE_STACK 5'h19
`define MODE_SPACE_STATIC 5'h1a
`define MODE_SPACE_PROGRAM 5'h1b
`define MODE_INDEX_BYTE 5'h1c
`define MODE_INDEX_WORD 5'h1d
`define MODE_INDEX_DOUBLE 5'h1e
`define MODE_INDEX_QUAD 5'h1f

// Dedicated base select, low two bits of memory-relative and memory-space codes
`define BASE_FRAME 2'h0
`define BASE_STACK 2'h1
`define BASE_STATIC 2'h2
`define BASE_PROGRAM 2'h3

// Index byte layout
`define INDEX_MODE_HI 7
`define INDEX_MODE_LO 3
`define INDEX_REG_HI 2
`define INDEX_REG_LO 0

// Link table entries are 4 bytes apart
`define LINK_ENTRY_SHIFT 2

// Operand kind reported on completion
`define KIND_REGISTER 2'h0
`define KIND_MEMORY 2'h1
`define KIND_IMMEDIATE 2'h2
`define KIND_RESERVED 2'h3

`endif

// *** rtl/ea_index_scaler.v ***
// Purpose: Adds a scaled index register to a base effective address
// Assumes: Scale code 0..3 means multiply by 1, 2, 4, 8
// Notes: Pure combinational; disabled input passes the base through
`timescale 1ns/10ps
`default_nettype none

module ea_index_scaler #(
  parameter ADDR_W = 32
) (
  // Operands
  input wire [ADDR_W-1:0] i_base,
  input wire [ADDR_W-1:0] i_index,
  input wire [1:0] i_scale,
  input wire i_enable,
  // Result
  output wire [ADDR_W-1:0] o_sum
);

  wire [ADDR_W-1:0] scaled;

  // Shift wraps at the address width, as the adder does
  assign scaled = i_index << i_scale;
  assign o_sum = i_enable ? (i_base + scaled) : i_base;

endmodule // ea_index_scaler

`default_nettype wire

// *** test/operand_mode_assertions.sv ***
// Purpose: Concurrent checks on the operand mode decoder ports
// Assumes: One clock domain, synchronous active-low reset
// Notes: Mode, direction, size and stack bit are captured on acceptance
`timescale 1ns/10ps
`default_nettype none
module operand_mode_checker #(
  parameter ADDR_W = 32
) (
  // Clock and request
  input wire i_clk,
  input wire i_rst_n,
  input wire i_start,
  input wire [4:0] i_mode,
  input wire i_write,
  input wire [1:0] i_size_log2,
  input wire i_stack_select,
  input wire o_busy,
  // Queue and pointer port
  input wire i_ext_valid,
  input wire o_ext_take,
  input wire o_ptr_req,
  input wire [ADDR_W-1:0] o_ptr_addr,
  input wire i_ptr_ack,
  // Result
  input wire o_done,
  input wire [1:0] o_kind,
  input wire o_illegal,
  input wire [2:0] o_reg_num,
  input wire [ADDR_W-1:0] o_ea,
  input wire o_stack_update,
  input wire o_stack_user,
  input wire [ADDR_W-1:0] o_stack_value
);
  logic [4:0] hm;
  logic hw;
  logic hs;
  logic [1:0] hz;
  // Request fields are gone by completion, so keep a copy
  always @(posedge i_clk) begin
    if (i_start && !o_busy) begin
      hm <= i_mode;
      hw <= i_write;
      hz <= i_size_log2;
      hs <= i_stack_select;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_go;
    i_start && !o_busy && i_mode < 5'h08;
  endsequence
  sequence s_fin;
    o_done && o_kind == 2'h0;
  endsequence
  sequence s_top;
    o_done && hm == 5'h17;
  endsequence
  property p_reg_time;
    s_go |-> ##3 s_fin;
  endproperty
  a_reg_time: assert property (p_reg_time) else $error("register done late");
  property p_reg_res;
    o_done && hm < 5'h08 |-> o_kind == 2'h0 && o_reg_num == hm[2:0];
  endproperty
  a_reg_res: assert property (p_reg_res) else $error("register result wrong");
  property p_resv;
    o_done && hm == 5'h13 |-> o_illegal && o_kind == 2'h3;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved code accepted");
  property p_imm;
    o_done && hm == 5'h14 |-> o_kind == 2'h2 && !o_illegal;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate kind wrong");
  property p_ptr_hold;
    o_ptr_req && !i_ptr_ack |=> o_ptr_req && $stable(o_ptr_addr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer request dropped");
  // No field may be swallowed while a pointer fetch is open or on the completion cycle
  property p_take;
    o_ext_take |-> i_ext_valid && o_busy && !o_ptr_req && !o_done;
  endproperty
  a_take: assert property (p_take) else $error("field taken out of turn");
  property p_push_pop;
    s_top |-> o_stack_update && o_stack_value == (hw ? o_ea : o_ea + (ADDR_W'(1) << hz));
  endproperty
  a_push_pop: assert property (p_push_pop) else $error("stack adjust wrong");
  property p_sel;
    s_top |-> o_stack_user == hs;
  endproperty
  a_sel: assert property (p_sel) else $error("stack pointer choice wrong");
  property p_upd_only;
    o_stack_update |-> o_done && (hm == 5'h17 || hm[4:2] == 3'h7);
  endproperty
  a_upd_only: assert property (p_upd_only) else $error("stray stack update");
endmodule // operand_mode_checker
bind operand_address_mode_decoder operand_mode_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// *** test/test_operand_address_mode_decoder.sv ***
// Purpose: Self-checking bench for the operand mode decoder
// Assumes: Queue always holds the next field; pointer reads answer after one cycle
// Notes: Pointer memory returns address plus 0x100
`timescale 1ns/10ps
`default_nettype none
module test_operand_address_mode_decoder;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic [4:0] i_mode = 5'h00;
  logic i_write = 1'b0;
  logic i_slave = 1'b0;
  logic [1:0] i_size_log2 = 2'h0;
  logic i_ext_valid = 1'b1;
  logic [31:0] i_ext_data = 32'h0;
  logic [255:0] i_gpr_flat;
  logic [31:0] i_frame_pointer = 32'h3000;
  logic [31:0] i_static_base = 32'h4000;
  logic [31:0] i_interrupt_stack_pointer = 32'h1000;
  logic [31:0] i_user_stack_pointer = 32'h2000;
  logic [31:0] i_program_counter = 32'h5000;
  logic [31:0] i_link_table_base = 32'h6000;
  logic i_stack_select = 1'b0;
  logic i_ptr_ack = 1'b0;
  logic [31:0] i_ptr_data = 32'h0;
  wire o_busy, o_ext_take, o_ptr_req, o_done, o_illegal, o_float_reg, o_stack_update;
  wire o_stack_user;
  wire [31:0] o_ptr_addr, o_ea, o_imm, o_stack_value;
  wire [1:0] o_kind;
  wire [2:0] o_reg_num;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int fi;
  logic [31:0] fq [2];
  logic [31:0] paddr;
  logic upd;
  operand_address_mode_decoder dut (.*);
  always #5 i_clk = ~i_clk;
  function automatic logic [31:0] g(input int n);
    return 32'h700 + 32'(n) * 32'h10;
  endfunction
  function automatic logic [31:0] base(input int k, input logic s);
    case (k)
      0: return i_frame_pointer;
      1: return s ? i_user_stack_pointer : i_interrupt_stack_pointer;
      2: return i_static_base;
      default: return i_program_counter;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    total_checks++;
    if (v !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Serves queue fields and pointer reads until completion
  task automatic run(input logic [4:0] m, input logic w, input logic [1:0] sz,
                     input logic [31:0] a, input logic [31:0] b);
    int n;
    fq = '{a, b};
    fi = 0;
    upd = 1'b0;
    i_mode <= m;
    i_write <= w;
    i_size_log2 <= sz;
    i_start <= 1'b1;
    i_ext_data <= a;
    @(posedge i_clk);
    i_start <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (o_ext_take === 1'b1) begin
        fi++;
        // Spent fields read back as garbage, never as the last value
        i_ext_data <= (fi < 2) ? fq[fi] : ~i_ext_data;
      end
      if (o_ptr_req === 1'b1 && i_ptr_ack === 1'b0) begin
        paddr = o_ptr_addr;
        i_ptr_ack <= 1'b1;
        i_ptr_data <= o_ptr_addr + 32'h100;
      end else begin
        i_ptr_ack <= 1'b0;
        i_ptr_data <= ~i_ptr_data;
      end
      if (o_done === 1'b1) begin
        upd = o_stack_update;
        break;
      end
    end
    if (n == 40)
      chk("done", 1, 0);
  endtask
  task automatic t_reg;
    for (int r = 0; r < 8; r++) begin
      i_slave <= r[0];
      run(5'(r), 1'b0, 2'h0, 32'h0, 32'h0);
      chk("kind", 0, o_kind);
      chk("reg", r, o_reg_num);
      chk("float", r[0], o_float_reg);
      chk("fields", 0, fi);
    end
  endtask
  task automatic t_rel;
    run(5'h0b, 1'b0, 2'h0, 32'h24, 32'h0);
    chk("ea", g(3) + 32'h24, o_ea);
    chk("kind", 1, o_kind);
    chk("fields", 1, fi);
    chk("upd", 0, upd);
  endtask
  task automatic t_memrel;
    for (int k = 0; k < 3; k++) begin
      i_stack_select <= k[0];
      run(5'h10 + 5'(k), 1'b0, 2'h0, 32'h8, 32'h4);
      chk("paddr", base(k, k[0]) + 32'h8, paddr);
      chk("ea", base(k, k[0]) + 32'h10c, o_ea);
      chk("fields", 2, fi);
    end
  endtask
  task automatic t_single;
    run(5'h13, 1'b0, 2'h0, 32'h55, 32'h0);
    chk("kind", 3, o_kind);
    chk("illegal", 1, o_illegal);
    chk("fields", 0, fi);
    run(5'h14, 1'b0, 2'h2, 32'h89ab_cdef, 32'h0);
    chk("imm", 32'h89ab_cdef, o_imm);
    chk("kind", 2, o_kind);
    chk("illegal", 0, o_illegal);
    run(5'h15, 1'b0, 2'h0, 32'h0012_3456, 32'h0);
    chk("ea", 32'h0012_3456, o_ea);
    chk("kind", 1, o_kind);
  endtask
  task automatic t_link;
    run(5'h16, 1'b0, 2'h0, 32'h3, 32'h20);
    chk("paddr", i_link_table_base + 32'hc, paddr);
    chk("ea", i_link_table_base + 32'h12c, o_ea);
  endtask
  task automatic t_top;
    i_stack_select <= 1'b0;
    run(5'h17, 1'b0, 2'h2, 32'h0, 32'h0);
    chk("ea", i_interrupt_stack_pointer, o_ea);
    chk("spv", i_interrupt_stack_pointer + 32'h4, o_stack_value);
    chk("spu", 0, o_stack_user);
    chk("upd", 1, upd);
    i_stack_select <= 1'b1;
    run(5'h17, 1'b1, 2'h3, 32'h0, 32'h0);
    chk("ea", i_user_stack_pointer - 32'h8, o_ea);
    chk("spv", i_user_stack_pointer - 32'h8, o_stack_value);
    chk("spu", 1, o_stack_user);
    chk("fields", 0, fi);
  endtask
  task automatic t_space;
    for (int k = 0; k < 4; k++) begin
      i_stack_select <= ~k[0];
      run(5'h18 + 5'(k), 1'b0, 2'h0, 32'h40, 32'h0);
      chk("ea", base(k, ~k[0]) + 32'h40, o_ea);
    end
  endtask
  task automatic t_index;
    for (int s = 0; s < 4; s++) begin
      run(5'h1c + 5'(s), 1'b0, 2'h0, 32'h42, 32'h30);
      chk("ea", g(0) + 32'h30 + (g(2) << s), o_ea);
      chk("fields", 2, fi);
    end
    // Register 2 direct as base, index register 5: base is the register contents
    run(5'h1c, 1'b0, 2'h0, 32'h15, 32'h30);
    chk("ea", g(2) + g(5), o_ea);
    chk("kind", 1, o_kind);
    chk("fields", 1, fi);
  endtask
  task automatic t_badidx;
    run(5'h1d, 1'b0, 2'h0, 32'ha1, 32'h30);
    chk("illegal", 1, o_illegal);
    run(5'h1c, 1'b0, 2'h0, 32'he1, 32'h30);
    chk("kind", 3, o_kind);
    chk("fields", 1, fi);
  endtask
  // Ceiling well above the roughly 150 cycles the sequence needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    for (int n = 0; n < 8; n++)
      i_gpr_flat[n*32 +: 32] <= g(n);
    repeat (16) @(posedge i_clk);
    chk("busy", 0, o_busy);
    chk("done", 0, o_done);
    i_rst_n <= 1'b1;
    t_reg;
    t_rel;
    t_memrel;
    t_single;
    t_link;
    t_top;
    t_space;
    t_index;
    t_badidx;
    stop_test;
  end
endmodule // test_operand_address_mode_decoder
`default_nettype wire
